//--- trfr_map.svh
// Register map, reset values, field positions and code limits
`ifndef TRFR_MAP_SVH
`define TRFR_MAP_SVH
`define TRFR_A_INT_DATA   8'h00
`define TRFR_A_EXT1_DATA  8'h01
`define TRFR_A_STATUS     8'h02
`define TRFR_A_CFG        8'h03
`define TRFR_A_RATE       8'h04
`define TRFR_A_INT_HI     8'h05
`define TRFR_A_INT_LO     8'h06
`define TRFR_A_EXT1_HI    8'h07
`define TRFR_A_EXT1_LO    8'h08
`define TRFR_A_CFG_M      8'h09
`define TRFR_A_RATE_M     8'h0A
`define TRFR_A_INT_HI_M   8'h0B
`define TRFR_A_INT_LO_M   8'h0C
`define TRFR_A_EXT1_HI_M  8'h0D
`define TRFR_A_EXT1_LO_M  8'h0E
`define TRFR_RST_CFG      8'h00
`define TRFR_RST_RATE     8'h06
`define TRFR_RST_HI       8'h55
`define TRFR_RST_LO       8'h00
`define TRFR_RST_STATUS   8'h00
`define TRFR_RST_DATA     11'h000
`define TRFR_RD_UNMAPPED  8'h00
`define TRFR_CFG_RANGE    2
`define TRFR_ST_EXT1_FLT  2
`define TRFR_ST_EXT1_LO   3
`define TRFR_ST_EXT1_HI   4
`define TRFR_ST_INT_LO    5
`define TRFR_ST_INT_HI    6
`define TRFR_CODE_ZERO    11'h000
`define TRFR_CODE_DEF_MAX 11'h3FF
`define TRFR_CODE_EXT_MAX 11'h7FF
`define TRFR_DEF_MIN_T    16'sh0000
`define TRFR_DEF_MAX_T    16'sh03FF
`define TRFR_EXT_MIN_T    16'shFE00
`define TRFR_EXT_MAX_T    16'sh05FF
`define TRFR_EXT_OFS      16'sh0200
`define TRFR_BITS_BYTE    4'h8
`define TRFR_BIT_LAST     4'h7
`endif

//--- trfr_pkg.sv
// Types shared by the result formatter and its register slave
package trfr_pkg;
  typedef enum logic [1:0] {TRFR_FILT_OFF, TRFR_FILT_L1, TRFR_FILT_L2} trfr_filt_e;
  typedef enum logic [3:0] {
    TRFR_S_IDLE, TRFR_S_ADDR, TRFR_S_PTR, TRFR_S_WDATA, TRFR_S_ACK,
    TRFR_S_RDATA, TRFR_S_RACK, TRFR_S_WAIT
  } trfr_smb_e;
endpackage

//--- trfr_regs.sv
// Temperature result formatting, limit compare and SMBus register slave
`timescale 1ns/10ps
`include "trfr_map.svh"

// What this block does
// - Results are 11 bits; upper eight bits sit in the high byte register.
// - Three low result bits fill low byte bits 7:5; the rest read zero.
// - Each stored result is compared with its channel's high and low limits.
// - Default range: plain binary, 0 to 127.875 degrees, eighth-degree steps.
// - Extended range: binary plus 64 degrees, covering -64 to 191.875 degrees.
// - Default range: anything below zero reads as the all-zero code.
// - Default range: anything above 127.875 saturates to 011 1111 1111.
// - Extended range: anything below -64 reads as the all-zero code.
// - Extended range: anything above 191.875 saturates to all ones.
// - A diode fault gives an all-zero result in either range.
// - A faulted result skips the low limit comparison.
// - First external channel only gets a filter: level one, two or off.
// - All registers except the low result bytes are reached over SMBus; the low bytes only leave on the intLowByte and ext1LowByte ports.
// - Unused status and low byte bits read as zero; configuration bits other than the range bit read back as written.
// - Configuration sits at 03h and 09h, one storage, reset 00h.
// - Conversion rate sits at 04h and 0Ah, reset 06h.
// - Internal high limit at 05h and 0Bh, reset 55h.
// - Internal low limit at 06h and 0Ch, reset 00h.
// - External high limit integer at 07h and 0Dh, reset 55h.
// - External low limit integer at 08h and 0Eh, reset 00h.
// - Integer temperature bytes read-only at 00h and 01h, reset 00h.
// - Read-only status at 02h, reset 00h, gathers all channel flags.
module trfr_regs #(
  parameter int         RAW_W      = 14,
  parameter logic [6:0] SLAVE_ADDR = 7'h2A
) (
  // System clock domain
  input  logic                  clk_sys,
  input  logic                  rst,
  input  logic                  ce,
  // Link clock domain
  input  logic                  clk_link,
  // SMBus pins
  input  logic                  smbClk,
  input  logic                  smbDataIn,
  output logic                  smbDataOut,
  output logic                  smbDataOe_n,
  // Conversion results
  input  logic                  convDone,
  input  logic signed [RAW_W-1:0] intRaw,
  input  logic signed [RAW_W-1:0] ext1Raw,
  input  logic                  ext1Fault,
  input  trfr_pkg::trfr_filt_e  filterSel,
  // Result side outputs
  output logic [7:0]            intLowByte,
  output logic [7:0]            ext1LowByte,
  output logic [7:0]            convRateSel
);
  import trfr_pkg::*;

  // Link domain
  logic [1:0]      rstLinkSync_r;
  logic            rstLink;
  logic [1:0]      ceSync_r;
  logic            ceLink;
  logic [2:0]      sclSync_r;
  logic [2:0]      sdaSync_r;
  logic            sclF_r;
  logic            sdaF_r;
  logic            sclPrev_r;
  logic            sdaPrev_r;
  logic            sclRise;
  logic            sclFall;
  logic            startCond;
  logic            stopCond;
  trfr_smb_e       state_r;
  trfr_smb_e       ackNext_r;
  logic [3:0]      bitCnt_r;
  logic [7:0]      shIn_r;
  logic [7:0]      shOut_r;
  logic [7:0]      ptr_r;
  logic            sdaDrive_r;
  logic            reqTog_r;
  logic            reqWr_r;
  logic [7:0]      reqAddr_r;
  logic [7:0]      reqData_r;
  logic [2:0]      ackSync_r;
  logic [7:0]      rdCap_r;
  // System domain
  logic [2:0]      reqSync_r;
  logic            reqEdge;
  logic            ackTog_r;
  logic [7:0]      rdData_r;
  logic [7:0]      rdMux;
  logic [7:0]      cfg_r;
  logic [7:0]      rate_r;
  logic [7:0]      intHi_r;
  logic [7:0]      intLo_r;
  logic [7:0]      extHi_r;
  logic [7:0]      extLo_r;
  logic [7:0]      status_r;
  logic [10:0]     intData_r;
  logic [10:0]     extData_r;
  logic            cmpPend_r;
  logic            faultHold_r;
  logic signed [15:0] filtAcc_r;
  logic            filtPrimed_r;
  logic signed [15:0] filtOut;
  logic signed [15:0] intT;
  logic signed [15:0] extT;
  logic signed [16:0] sumL1;
  logic signed [16:0] diffL2;
  logic            rangeExt;

  function automatic logic [10:0] trfrEncode(input logic signed [15:0] t,
                                             input logic ext, input logic fault);
    logic signed [15:0] s;
    s = t + `TRFR_EXT_OFS;
    if (fault) begin
      trfrEncode = `TRFR_CODE_ZERO;
    end else if (!ext) begin
      if (t < `TRFR_DEF_MIN_T) begin
        trfrEncode = `TRFR_CODE_ZERO;
      end else if (t > `TRFR_DEF_MAX_T) begin
        trfrEncode = `TRFR_CODE_DEF_MAX;
      end else begin
        trfrEncode = t[10:0];
      end
    end else begin
      if (t < `TRFR_EXT_MIN_T) begin
        trfrEncode = `TRFR_CODE_ZERO;
      end else if (t > `TRFR_EXT_MAX_T) begin
        trfrEncode = `TRFR_CODE_EXT_MAX;
      end else begin
        trfrEncode = s[10:0];
      end
    end
  endfunction

  // Link reset release and clock enable, two stages each
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      rstLinkSync_r <= 2'h3;
      ceSync_r      <= 2'h0;
    end else begin
      rstLinkSync_r <= {rstLinkSync_r[0], 1'b0};
      ceSync_r      <= {ceSync_r[0], ce};
    end
  end
  assign rstLink = rstLinkSync_r[1];
  assign ceLink  = ceSync_r[1];

  // Pin filtering: stages two and three must agree
  always_ff @(posedge clk_link or posedge rstLink) begin
    if (rstLink) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
      sclF_r    <= 1'b1;
      sdaF_r    <= 1'b1;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclSync_r <= {sclSync_r[1:0], smbClk};
      sdaSync_r <= {sdaSync_r[1:0], smbDataIn};
      if (sclSync_r[1] == sclSync_r[2]) begin
        sclF_r <= sclSync_r[2];
      end
      if (sdaSync_r[1] == sdaSync_r[2]) begin
        sdaF_r <= sdaSync_r[2];
      end
      sclPrev_r <= sclF_r;
      sdaPrev_r <= sdaF_r;
    end
  end
  assign sclRise   = sclF_r && !sclPrev_r;
  assign sclFall   = !sclF_r && sclPrev_r;
  assign startCond = sclF_r && sclPrev_r && sdaPrev_r && !sdaF_r;
  assign stopCond  = sclF_r && sclPrev_r && !sdaPrev_r && sdaF_r;

  always_ff @(posedge clk_link or posedge rstLink) begin
    if (rstLink) begin
      state_r    <= TRFR_S_IDLE;
      ackNext_r  <= TRFR_S_IDLE;
      bitCnt_r   <= 4'h0;
      shIn_r     <= 8'h00;
      shOut_r    <= 8'h00;
      ptr_r      <= 8'h00;
      sdaDrive_r <= 1'b0;
      reqTog_r   <= 1'b0;
      reqWr_r    <= 1'b0;
      reqAddr_r  <= 8'h00;
      reqData_r  <= 8'h00;
    end else if (ceLink) begin
      if (stopCond) begin
        state_r    <= TRFR_S_IDLE;
        sdaDrive_r <= 1'b0;
      end else if (startCond) begin
        state_r    <= TRFR_S_ADDR;
        bitCnt_r   <= 4'h0;
        sdaDrive_r <= 1'b0;
      end else begin
        case (state_r)
          TRFR_S_ADDR, TRFR_S_PTR, TRFR_S_WDATA: begin
            if (sclRise) begin
              shIn_r   <= {shIn_r[6:0], sdaF_r};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == `TRFR_BITS_BYTE) begin
              bitCnt_r   <= 4'h0;
              sdaDrive_r <= 1'b1;
              state_r    <= TRFR_S_ACK;
              if (state_r == TRFR_S_ADDR) begin
                if (shIn_r[7:1] != SLAVE_ADDR) begin
                  sdaDrive_r <= 1'b0;
                  state_r    <= TRFR_S_WAIT;
                end else if (shIn_r[0]) begin
                  ackNext_r <= TRFR_S_RDATA;
                  reqWr_r   <= 1'b0;
                  reqAddr_r <= ptr_r;
                  reqTog_r  <= !reqTog_r;
                end else begin
                  ackNext_r <= TRFR_S_PTR;
                end
              end else if (state_r == TRFR_S_PTR) begin
                ptr_r     <= shIn_r;
                ackNext_r <= TRFR_S_WDATA;
              end else begin
                reqWr_r   <= 1'b1;
                reqAddr_r <= ptr_r;
                reqData_r <= shIn_r;
                reqTog_r  <= !reqTog_r;
                ackNext_r <= TRFR_S_WDATA;
              end
            end
          end
          TRFR_S_ACK: begin
            if (sclFall) begin
              state_r    <= ackNext_r;
              bitCnt_r   <= 4'h0;
              sdaDrive_r <= (ackNext_r == TRFR_S_RDATA) ? !rdCap_r[7] : 1'b0;
              shOut_r    <= rdCap_r;
            end
          end
          TRFR_S_RDATA: begin
            if (sclFall) begin
              bitCnt_r <= bitCnt_r + 4'h1;
              if (bitCnt_r == `TRFR_BIT_LAST) begin
                sdaDrive_r <= 1'b0;
                state_r    <= TRFR_S_RACK;
              end else begin
                shOut_r    <= {shOut_r[6:0], 1'b0};
                sdaDrive_r <= !shOut_r[6];
              end
            end
          end
          TRFR_S_RACK: begin
            if (sclRise) begin
              if (sdaF_r) begin
                state_r <= TRFR_S_WAIT;
              end else begin
                reqWr_r   <= 1'b0;
                reqAddr_r <= ptr_r;
                reqTog_r  <= !reqTog_r;
                ackNext_r <= TRFR_S_RDATA;
                state_r   <= TRFR_S_ACK;
              end
            end
          end
          TRFR_S_IDLE, TRFR_S_WAIT: begin
            sdaDrive_r <= 1'b0;
          end
          default: begin
            state_r    <= TRFR_S_IDLE;
            sdaDrive_r <= 1'b0;
          end
        endcase
      end
    end
  end
  assign smbDataOut  = 1'b0;
  assign smbDataOe_n = !sdaDrive_r;

  // Read answer capture, stable once the answer toggle is seen
  always_ff @(posedge clk_link or posedge rstLink) begin
    if (rstLink) begin
      ackSync_r <= 3'h0;
      rdCap_r   <= 8'h00;
    end else begin
      ackSync_r <= {ackSync_r[1:0], ackTog_r};
      if (ackSync_r[2] != ackSync_r[1]) begin
        rdCap_r <= rdData_r;
      end
    end
  end

  // Request handshake into the system domain
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reqSync_r <= 3'h0;
      ackTog_r  <= 1'b0;
      rdData_r  <= 8'h00;
    end else if (ce) begin
      reqSync_r <= {reqSync_r[1:0], reqTog_r};
      if (reqEdge) begin
        ackTog_r <= !ackTog_r;
        rdData_r <= rdMux;
      end
    end
  end
  assign reqEdge = reqSync_r[2] != reqSync_r[1];

  // read mux, unmapped addresses read zero
  always_comb begin
    rdMux = `TRFR_RD_UNMAPPED;
    case (reqAddr_r)
      `TRFR_A_INT_DATA:                     rdMux = intData_r[10:3];
      `TRFR_A_EXT1_DATA:                    rdMux = extData_r[10:3];
      `TRFR_A_STATUS:                       rdMux = status_r;
      `TRFR_A_CFG, `TRFR_A_CFG_M:           rdMux = cfg_r;
      `TRFR_A_RATE, `TRFR_A_RATE_M:         rdMux = rate_r;
      `TRFR_A_INT_HI, `TRFR_A_INT_HI_M:     rdMux = intHi_r;
      `TRFR_A_INT_LO, `TRFR_A_INT_LO_M:     rdMux = intLo_r;
      `TRFR_A_EXT1_HI, `TRFR_A_EXT1_HI_M:   rdMux = extHi_r;
      `TRFR_A_EXT1_LO, `TRFR_A_EXT1_LO_M:   rdMux = extLo_r;
      default:                              rdMux = `TRFR_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_r   <= `TRFR_RST_CFG;
      rate_r  <= `TRFR_RST_RATE;
      intHi_r <= `TRFR_RST_HI;
      intLo_r <= `TRFR_RST_LO;
      extHi_r <= `TRFR_RST_HI;
      extLo_r <= `TRFR_RST_LO;
    end else if (ce && reqEdge && reqWr_r) begin
      case (reqAddr_r)
        `TRFR_A_CFG, `TRFR_A_CFG_M:         cfg_r   <= reqData_r;
        `TRFR_A_RATE, `TRFR_A_RATE_M:       rate_r  <= reqData_r;
        `TRFR_A_INT_HI, `TRFR_A_INT_HI_M:   intHi_r <= reqData_r;
        `TRFR_A_INT_LO, `TRFR_A_INT_LO_M:   intLo_r <= reqData_r;
        `TRFR_A_EXT1_HI, `TRFR_A_EXT1_HI_M: extHi_r <= reqData_r;
        `TRFR_A_EXT1_LO, `TRFR_A_EXT1_LO_M: extLo_r <= reqData_r;
        default: ;
      endcase
    end
  end
  assign convRateSel = rate_r;
  assign rangeExt    = cfg_r[`TRFR_CFG_RANGE];

  // filter on the first external channel
  assign intT   = 16'(intRaw);
  assign extT   = 16'(ext1Raw);
  assign sumL1  = {filtAcc_r[15], filtAcc_r} + {extT[15], extT};
  assign diffL2 = {extT[15], extT} - {filtAcc_r[15], filtAcc_r};
  always_comb begin
    filtOut = extT;
    if (filtPrimed_r) begin
      case (filterSel)
        TRFR_FILT_L1: filtOut = sumL1[16:1];
        TRFR_FILT_L2: filtOut = filtAcc_r + {diffL2[16], diffL2[16:2]};
        default:      filtOut = extT;
      endcase
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filtAcc_r    <= `TRFR_DEF_MIN_T;
      filtPrimed_r <= 1'b0;
    end else if (ce && convDone && !ext1Fault) begin
      filtAcc_r    <= filtOut;
      filtPrimed_r <= 1'b1;
    end
  end

  // results encoded once, at store time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      intData_r   <= `TRFR_RST_DATA;
      extData_r   <= `TRFR_RST_DATA;
      cmpPend_r   <= 1'b0;
      faultHold_r <= 1'b0;
    end else if (ce) begin
      cmpPend_r <= convDone;
      if (convDone) begin
        intData_r   <= trfrEncode(intT, rangeExt, 1'b0);
        extData_r   <= trfrEncode(filtOut, rangeExt, ext1Fault);
        faultHold_r <= ext1Fault;
      end
    end
  end
  assign intLowByte  = {intData_r[2:0], 5'h00};
  assign ext1LowByte = {extData_r[2:0], 5'h00};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_r <= `TRFR_RST_STATUS;
    end else if (ce && cmpPend_r) begin
      status_r[`TRFR_ST_INT_HI]   <= intData_r[10:3] >= intHi_r;
      status_r[`TRFR_ST_INT_LO]   <= intData_r[10:3] < intLo_r;
      status_r[`TRFR_ST_EXT1_HI]  <= extData_r[10:3] >= extHi_r;
      status_r[`TRFR_ST_EXT1_LO]  <= !faultHold_r && (extData_r[10:3] < extLo_r);
      status_r[`TRFR_ST_EXT1_FLT] <= faultHold_r;
    end
  end

  sequence seqStore;
    ce && convDone ##1 ce;
  endsequence
  sequence seqFaultStore;
    ce && convDone && ext1Fault ##1 ce;
  endsequence

  AST_FAULT_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    ce && convDone && ext1Fault |=> extData_r == `TRFR_CODE_ZERO)
    else $error("faulted result not zero");
  AST_DEF_BELOW: assert property (@(posedge clk_sys) disable iff (rst)
    ce && convDone && !rangeExt && intT < `TRFR_DEF_MIN_T |=> intData_r == `TRFR_CODE_ZERO)
    else $error("default range negative not zero");
  AST_DEF_SAT: assert property (@(posedge clk_sys) disable iff (rst)
    ce && convDone && !rangeExt && intT > `TRFR_DEF_MAX_T |=> intData_r == `TRFR_CODE_DEF_MAX)
    else $error("default range not saturated");
  AST_EXT_BELOW: assert property (@(posedge clk_sys) disable iff (rst)
    ce && convDone && rangeExt && intT < `TRFR_EXT_MIN_T |=> intData_r == `TRFR_CODE_ZERO)
    else $error("extended range low not zero");
  AST_EXT_SAT: assert property (@(posedge clk_sys) disable iff (rst)
    ce && convDone && rangeExt && intT > `TRFR_EXT_MAX_T |=> intData_r == `TRFR_CODE_EXT_MAX)
    else $error("extended range not saturated");
  AST_EXT_OFS: assert property (@(posedge clk_sys) disable iff (rst)
    ce && convDone && rangeExt && intT >= `TRFR_EXT_MIN_T && intT <= `TRFR_EXT_MAX_T
    |=> intData_r == 11'($past(intT) + `TRFR_EXT_OFS))
    else $error("extended offset wrong");
  AST_LOW_BYTE: assert property (@(posedge clk_sys) disable iff (rst)
    ext1LowByte[4:0] == 5'h00 && ext1LowByte[7:5] == extData_r[2:0])
    else $error("low byte layout wrong");
  AST_CMP_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
    seqStore |=> status_r[`TRFR_ST_INT_HI] == ($past(intData_r[10:3]) >= $past(intHi_r)))
    else $error("high compare wrong");
  AST_FAULT_NO_LOW: assert property (@(posedge clk_sys) disable iff (rst)
    seqFaultStore |=> !status_r[`TRFR_ST_EXT1_LO] && status_r[`TRFR_ST_EXT1_FLT])
    else $error("low compare not skipped");
  AST_CFG_MIRROR: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reqEdge && reqWr_r && reqAddr_r == `TRFR_A_CFG_M |=> cfg_r == $past(reqData_r))
    else $error("mirror write missed");
  AST_BUS_RELEASE: assert property (@(posedge clk_link) disable iff (rstLink)
    state_r == TRFR_S_IDLE ##1 state_r == TRFR_S_IDLE |-> !sdaDrive_r)
    else $error("data driven while idle");
endmodule

//--- trfr_smb_host.sv
// SMBus host model that reaches the registers through the pins
`timescale 1ns/10ps
module trfr_smb_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter int         H        = 20
) (
  // Pacing clock
  input  wire logic clk,
  // Bus pins
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sda
);
  initial begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    sdaLow = 1'h0;
    hw(H);
    scl = 1'h1;
    hw(H);
    sdaLow = 1'h1;
    hw(H);
    scl = 1'h0;
  endtask
  task automatic stop();
    hw(H);
    sdaLow = 1'h1;
    hw(H);
    scl = 1'h1;
    hw(H);
    sdaLow = 1'h0;
    hw(H);
  endtask
  // Released line reads the pull-up level
  task automatic bitIo(input logic bOut, output logic bIn);
    hw(H);
    sdaLow = ~bOut;
    hw(H);
    scl = 1'h1;
    hw(H);
    bIn = sda;
    hw(H);
    scl = 1'h0;
  endtask
  task automatic byteIo(input logic [7:0] dOut, input logic ackOut,
                        output logic [7:0] dIn, output logic ackIn);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitIo(dOut[i], b);
      dIn[i] = b;
    end
    bitIo(ackOut, b);
    ackIn = ~b;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic       a0, a1, a2;
    start();
    byteIo({DEV_ADDR, 1'h0}, 1'h1, x, a0);
    byteIo(ptr, 1'h1, x, a1);
    byteIo(d, 1'h1, x, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic       a0, a1, a2, a3;
    start();
    byteIo({DEV_ADDR, 1'h0}, 1'h1, x, a0);
    byteIo(ptr, 1'h1, x, a1);
    start();
    byteIo({DEV_ADDR, 1'h1}, 1'h1, x, a2);
    byteIo(8'hFF, 1'h1, d, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // pointer then two reads, master ACK then NACK
  task automatic rd2(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1,
                     output logic ok);
    logic [7:0] x;
    logic       a0, a1, a2, a3;
    start();
    byteIo({DEV_ADDR, 1'h0}, 1'h1, x, a0);
    byteIo(ptr, 1'h1, x, a1);
    start();
    byteIo({DEV_ADDR, 1'h1}, 1'h1, x, a2);
    byteIo(8'hFF, 1'h0, d0, a3);
    byteIo(8'hFF, 1'h1, d1, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic probe(input logic [6:0] adr, output logic ack);
    logic [7:0] x;
    start();
    byteIo({adr, 1'h0}, 1'h1, x, ack);
    stop();
  endtask
endmodule

//--- test_trfr_regs.sv
// Self-checking bench for the result formatter and register slave
`timescale 1ns/10ps
module test_trfr_regs;
  import trfr_pkg::*;
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam int         LIMIT    = 100000;
  logic               clkSys = 1'h0;
  logic               clkLink = 1'h0;
  logic               rst;
  logic               convDone;
  logic signed [13:0] intRaw;
  logic signed [13:0] ext1Raw;
  logic               ext1Fault;
  trfr_filt_e         filterSel;
  logic               scl;
  logic               hostLow;
  wire                sdaWire;
  logic               sdaOut;
  logic               sdaOe_n;
  logic [7:0]         intLow;
  logic [7:0]         ext1Low;
  logic [7:0]         rateSel;
  logic [7:0]         rdData;
  logic [7:0]         rdAgain;
  logic               ok;
  int                 nErrors = 0;
  int                 checksDone = 0;
  int                 cycles = 0;
  logic [7:0]         rstVals [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h55, 8'h00, 8'h55,
                                      8'h00};

  always #10 clkSys = ~clkSys;
  always #32 clkLink = ~clkLink;

  // Open-drain line with pull-up
  assign sdaWire = !hostLow && (sdaOe_n || sdaOut);

  trfr_regs #(.SLAVE_ADDR(DEV_ADDR)) DUT (
    .clk_sys(clkSys), .rst(rst), .ce(1'h1), .clk_link(clkLink),
    .smbClk(scl), .smbDataIn(sdaWire), .smbDataOut(sdaOut), .smbDataOe_n(sdaOe_n),
    .convDone(convDone), .intRaw(intRaw), .ext1Raw(ext1Raw), .ext1Fault(ext1Fault),
    .filterSel(filterSel), .intLowByte(intLow), .ext1LowByte(ext1Low), .convRateSel(rateSel)
  );

  trfr_smb_host #(.DEV_ADDR(DEV_ADDR)) host (
    .clk(clkSys), .scl(scl), .sdaLow(hostLow), .sda(sdaWire)
  );

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic endSim();
    if (nErrors == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, ok);
    chk("write ack", {7'h00, ok}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rdData, ok);
    chk("read ack", {7'h00, ok}, 8'h01);
    chk($sformatf("reg %h", a), rdData, exp);
  endtask

  // Expected code from raw eighth-degree value
  function automatic logic [10:0] enc(input logic signed [15:0] raw, input logic ext,
                                      input logic flt);
    logic signed [15:0] v;
    v = ext ? raw + 16'sh0200 : raw;
    if (flt || v < 0) return 11'h000;
    if (v > (ext ? 16'sh07FF : 16'sh03FF)) return ext ? 11'h7FF : 11'h3FF;
    return v[10:0];
  endfunction

  task automatic conv(input logic signed [13:0] iR, input logic signed [13:0] eR,
                      input logic f, input logic ext, input logic [10:0] eCode);
    logic [10:0] iCode;
    iCode = enc(iR, ext, 1'h0);
    @(negedge clkSys);
    convDone = 1'h1;
    intRaw = iR;
    ext1Raw = eR;
    ext1Fault = f;
    @(negedge clkSys);
    convDone = 1'h0;
    @(negedge clkSys);
    chk("intLowByte", intLow, {iCode[2:0], 5'h00});
    chk("ext1LowByte", ext1Low, {eCode[2:0], 5'h00});
  endtask

  always @(posedge clkSys) begin
    cycles++;
    if (cycles == LIMIT) begin
      nErrors++;
      endSim();
    end
  end

  initial begin
    rst = 1'h1;
    convDone = 1'h0;
    intRaw = 14'sh0000;
    ext1Raw = 14'sh0000;
    ext1Fault = 1'h0;
    filterSel = TRFR_FILT_OFF;
    repeat (16) @(negedge clkSys);
    chk("intLowByte", intLow, 8'h00);
    chk("convRateSel", rateSel, 8'h06);
    rst = 1'h0;
    repeat (20) @(negedge clkSys);
    for (int i = 0; i < 9; i++) rd(i[7:0], rstVals[i]);
    rd(8'h3F, 8'h00);
    host.probe(7'h15, ok);
    chk("foreign ack", {7'h00, ok}, 8'h00);
    // Filter seeded by first sample
    filterSel = TRFR_FILT_L1;
    conv(14'sh0000, 14'sh0051, 1'h0, 1'h0, 11'h051);
    conv(14'sh0000, 14'sh00A3, 1'h0, 1'h0, 11'h07A);
    filterSel = TRFR_FILT_L2;
    conv(14'sh0000, 14'sh00CA, 1'h0, 1'h0, 11'h08E);
    rd(8'h01, 8'h11);
    filterSel = TRFR_FILT_OFF;
    conv(14'sh3FF9, 14'sh0001, 1'h0, 1'h0, enc(14'sh0001, 1'h0, 1'h0));
    conv(14'sh0400, 14'sh03FF, 1'h0, 1'h0, enc(14'sh03FF, 1'h0, 1'h0));
    wr(8'h00, 8'hAB);
    wr(8'h09, 8'h04);
    rd(8'h00, 8'h7F);
    rd(8'h03, 8'h04);
    wr(8'h0A, 8'h03);
    chk("convRateSel", rateSel, 8'h03);
    conv(14'sh0200, 14'sh3DFD, 1'h0, 1'h1, enc(14'sh3DFD, 1'h1, 1'h0));
    rd(8'h00, 8'h80);
    conv(14'sh3DFD, 14'sh3DFD, 1'h0, 1'h1, 11'h000);
    conv(14'sh0601, 14'sh05FF, 1'h0, 1'h1, enc(14'sh05FF, 1'h1, 1'h0));
    wr(8'h09, 8'h00);
    wr(8'h0B, 8'h20);
    wr(8'h0C, 8'h10);
    wr(8'h0D, 8'h40);
    wr(8'h0E, 8'h05);
    conv(14'sh0100, 14'sh0010, 1'h0, 1'h0, enc(14'sh0010, 1'h0, 1'h0));
    rd(8'h02, 8'h48);
    conv(14'sh007F, 14'sh0010, 1'h1, 1'h0, 11'h000);
    rd(8'h02, 8'h24);
    host.rd2(8'h02, rdData, rdAgain, ok);
    chk("reread ack", {7'h00, ok}, 8'h01);
    chk("reread first", rdData, 8'h24);
    chk("reread second", rdAgain, 8'h24);
    rd(8'h01, 8'h00);
    endSim();
  end
endmodule
